// ---- rtl/dsi_pkg.sv ----
// Package with offsets, field positions, reset values and codes of the block.
package dsi_pkg;
   // Register offsets in the access-layer map.
   localparam logic [3:0] OFF_KEY_STATE = 4'h7;
   localparam logic [3:0] OFF_RESET_REQ = 4'h8;
   localparam logic [3:0] OFF_CLK_CTRL = 4'h9;
   localparam logic [3:0] OFF_SYS_CTRL = 4'ha;
   localparam logic [3:0] OFF_SYS_STATE = 4'hb;
   localparam logic [3:0] OFF_CRC_STATE = 4'hc;
   // Field positions.
   localparam int KEY_UROW_BIT = 5;
   localparam int KEY_PROG_BIT = 4;
   localparam int KEY_ERASE_BIT = 3;
   localparam int RST_ACTIVE_BIT = 0;
   localparam int CTRL_COMMIT_BIT = 1;
   localparam int CTRL_SYSTEM_CLOCK_REQUEST_BIT = 0;
   localparam int ST_RESET_BIT = 5;
   localparam int ST_SLEEP_BIT = 4;
   localparam int ST_PROG_BIT = 3;
   localparam int ST_UROW_BIT = 2;
   localparam int ST_LOCK_BIT = 0;
   // Values and reset values.
   localparam logic [7:0] RESET_SIGNATURE = 8'h59;
   localparam logic [1:0] CLK_16MHZ = 2'h1;
   localparam logic [1:0] CLK_8MHZ = 2'h2;
   localparam logic [1:0] CLK_4MHZ = 2'h3;
   localparam logic [1:0] CLK_SEL_RESET = 2'h3;
   localparam logic [7:0] SYS_STATE_RESET = 8'h01;
   localparam logic [2:0] CRC_OFF = 3'h0;
   localparam logic [2:0] CRC_BUSY = 3'h1;
   localparam logic [2:0] CRC_PASS = 3'h2;
   localparam logic [2:0] CRC_FAIL = 3'h4;
   // Number of synchroniser stages for inputs from the system domain.
   localparam int SYNC_STAGES = 3;
endpackage : dsi_pkg

// ---- rtl/dsi_regs.sv ----
// Access-layer system interface registers of the one-wire debug port.

// Function
// - Key bit 5 shows user-row write key
// - Key bit 4 programming key, auto clears
// - Key bit 3 erase key, auto clears
// - Signature write asserts held system reset
// - Other value written releases reset
// - Read shows reset held on bit 0
// - System reset leaves port logic intact
// - Clock select 1/2/3 = 16/8/4 MHz
// - Commit bit starts user-row flash programming
// - Commit accepted only with user-row key
// - Clock request bit holds system clock request
// - Clock request set on enable, cleared disable
// - Status bit 5 reset active, clear on read
// - Status bit 4 shows system asleep
// - Status bit 3 programming may begin
// - Status bit 2 user-row programming may begin
// - Status bit 0 locked, reset value one
// - CRC field one-hot state code
// - Registers reachable only by port instructions
// - Port disable drops request, resets keys
module dsi_regs (
   // Clock and reset of the debug port.
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   // Port enable; low means the physical interface is disabled.
   input wire logic PORT_ENABLE,
   // Access-layer register port, driven by the port's instruction decoder.
   input wire logic [3:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   // Key decoder levels, and key completion pulses from the system.
   input wire logic USER_ROW_WRITE_KEY_IN,
   input wire logic FLASH_PROGRAM_KEY_IN,
   input wire logic ERASE_KEY_IN,
   input wire logic PROG_DONE_IN,
   input wire logic ERASE_DONE_IN,
   // Status levels from the system domain.
   input wire logic SYSTEM_RESET_IN,
   input wire logic SYSTEM_ASLEEP_IN,
   input wire logic FLASH_PROG_READY_IN,
   input wire logic USER_ROW_PROG_READY_IN,
   input wire logic DEVICE_LOCKED_IN,
   input wire logic [2:0] CRC_STATE_IN,
   // Controls towards the system domain.
   output logic SYSTEM_RESET_HOLD,
   output logic SYSTEM_CLOCK_REQUEST,
   output logic USER_ROW_COMMIT,
   output logic [1:0] DEBUG_CLOCK_CHOICE
);
   logic [7:0] sync_in;
   logic [7:0] sync_out;
   logic sys_rst_s;
   logic asleep_s;
   logic prog_rdy_s;
   logic urow_rdy_s;
   logic locked_s;
   logic [2:0] crc_s;
   logic key_urow_r;
   logic key_prog_r;
   logic key_erase_r;
   logic reset_hold_r;
   logic system_clock_request_r;
   logic commit_r;
   logic [1:0] clk_sel_r;
   logic rst_seen_r;
   logic lock_r;
   logic [2:0] lock_settle_r;
   logic [2:0] crc_d_r;
   logic [2:0] crc_r;
   logic en_d_r;
   logic en_rise;
   logic [7:0] rdata_nxt;
   logic wr_rst;
   logic wr_clk;
   logic wr_ctrl;
   logic rd_state;

   // Edges after reset release until a level has crossed the whole bank.
   localparam logic [2:0] lock_settle_end = 3'(dsi_pkg::SYNC_STAGES + 1);

   // Levels from the system domain pass the synchroniser bank.
   assign sync_in = {SYSTEM_RESET_IN, SYSTEM_ASLEEP_IN, FLASH_PROG_READY_IN,
                     USER_ROW_PROG_READY_IN, DEVICE_LOCKED_IN, CRC_STATE_IN};

   dsi_sync #(
      .WIDTH(8)
   ) u_sync (
      .clk(CLK_SYS),
      .rst(SYS_RST),
      .din(sync_in),
      .dout(sync_out)
   );

   assign sys_rst_s = sync_out[7];
   assign asleep_s = sync_out[6];
   assign prog_rdy_s = sync_out[5];
   assign urow_rdy_s = sync_out[4];
   assign locked_s = sync_out[3];
   assign crc_s = sync_out[2:0];

   // Strobes are only formed from the port's own instructions.
   assign wr_rst = REG_WR && (REG_ADDR == dsi_pkg::OFF_RESET_REQ);
   assign wr_clk = REG_WR && (REG_ADDR == dsi_pkg::OFF_CLK_CTRL);
   assign wr_ctrl = REG_WR && (REG_ADDR == dsi_pkg::OFF_SYS_CTRL);
   assign rd_state = REG_RD && (REG_ADDR == dsi_pkg::OFF_SYS_STATE);

   // User-row key follows the decoder; the others are set by it and held until completions clear them; disable wipes.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         key_urow_r <= 1'b0;
         key_prog_r <= 1'b0;
         key_erase_r <= 1'b0;
      end else if (!PORT_ENABLE) begin
         key_urow_r <= 1'b0;
         key_prog_r <= 1'b0;
         key_erase_r <= 1'b0;
      end else begin
         key_urow_r <= USER_ROW_WRITE_KEY_IN;
         if (PROG_DONE_IN) begin
            key_prog_r <= 1'b0;
         end else if (FLASH_PROGRAM_KEY_IN) begin
            key_prog_r <= 1'b1;
         end
         if (ERASE_DONE_IN) begin
            key_erase_r <= 1'b0;
         end else if (ERASE_KEY_IN) begin
            key_erase_r <= 1'b1;
         end
      end
   end

   // Reset request: the port reset or a non-signature write clears it, never the system reset.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         reset_hold_r <= 1'b0;
      end else if (wr_rst) begin
         // Signature holds the reset, anything else releases it.
         reset_hold_r <= (REG_WDATA == dsi_pkg::RESET_SIGNATURE);
      end
   end

   // Debug clock choice; reserved code zero is ignored.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         clk_sel_r <= dsi_pkg::CLK_SEL_RESET;
      end else if (!PORT_ENABLE) begin
         clk_sel_r <= dsi_pkg::CLK_SEL_RESET;
      end else if (wr_clk && (REG_WDATA[1:0] != 2'h0)) begin
         clk_sel_r <= REG_WDATA[1:0];
      end
   end

   // Enable edge detection; its reset value of zero makes a port that is
   // enabled straight out of reset count as a fresh enable.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         en_d_r <= 1'b0;
      end else begin
         en_d_r <= PORT_ENABLE;
      end
   end

   // One cycle high on each rising edge of the port enable.
   assign en_rise = PORT_ENABLE && !en_d_r;

   // Clock request: set on each enable, cleared on disable, and written by
   // the debugger in between; the enable edge wins over a same-cycle write.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         system_clock_request_r <= 1'b0;
      end else if (!PORT_ENABLE) begin
         system_clock_request_r <= 1'b0;
      end else if (en_rise) begin
         system_clock_request_r <= 1'b1;
      end else if (wr_ctrl) begin
         system_clock_request_r <= REG_WDATA[dsi_pkg::CTRL_SYSTEM_CLOCK_REQUEST_BIT];
      end
   end

   // User-row commit: a one-cycle start pulse, taken only with the key.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         commit_r <= 1'b0;
      end else begin
         commit_r <= wr_ctrl && key_urow_r && PORT_ENABLE
                     && REG_WDATA[dsi_pkg::CTRL_COMMIT_BIT];
      end
   end

   // Sticky reset flag; a new reset wins over the read that clears it.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         rst_seen_r <= 1'b0;
      end else if (sys_rst_s || reset_hold_r) begin
         rst_seen_r <= 1'b1;
      end else if (rd_state) begin
         rst_seen_r <= 1'b0;
      end
   end

   // Counts the edges after reset release until the synchroniser bank has
   // filled; before that its outputs still show their own reset values.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         lock_settle_r <= 3'h0;
      end else if (lock_settle_r != lock_settle_end) begin
         lock_settle_r <= lock_settle_r + 3'h1;
      end
   end

   // Lock status keeps its reset value of one until the bank has settled,
   // so a locked device never reads as unlocked just after reset.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         lock_r <= 1'b1;
      end else if (lock_settle_r == lock_settle_end) begin
         lock_r <= locked_s;
      end
   end

   // The scan code moves several bits at once; it is taken only once the
   // whole synchronised word has held still, so no mixed code is shown.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         crc_d_r <= dsi_pkg::CRC_OFF;
         crc_r <= dsi_pkg::CRC_OFF;
      end else begin
         crc_d_r <= crc_s;
         if (crc_d_r == crc_s) begin
            crc_r <= crc_s;
         end
      end
   end

   // Read multiplexer; unused bits and unmapped offsets read zero.
   always_comb begin
      rdata_nxt = 8'h00;
      case (REG_ADDR)
         dsi_pkg::OFF_KEY_STATE: begin
            rdata_nxt[dsi_pkg::KEY_UROW_BIT] = key_urow_r;
            rdata_nxt[dsi_pkg::KEY_PROG_BIT] = key_prog_r;
            rdata_nxt[dsi_pkg::KEY_ERASE_BIT] = key_erase_r;
         end
         dsi_pkg::OFF_RESET_REQ: begin
            rdata_nxt[dsi_pkg::RST_ACTIVE_BIT] = reset_hold_r;
         end
         dsi_pkg::OFF_CLK_CTRL: begin
            rdata_nxt[1:0] = clk_sel_r;
         end
         dsi_pkg::OFF_SYS_CTRL: begin
            rdata_nxt[dsi_pkg::CTRL_SYSTEM_CLOCK_REQUEST_BIT] = system_clock_request_r;
         end
         dsi_pkg::OFF_SYS_STATE: begin
            rdata_nxt[dsi_pkg::ST_RESET_BIT] = rst_seen_r;
            rdata_nxt[dsi_pkg::ST_SLEEP_BIT] = asleep_s;
            rdata_nxt[dsi_pkg::ST_PROG_BIT] = prog_rdy_s;
            rdata_nxt[dsi_pkg::ST_UROW_BIT] = urow_rdy_s;
            rdata_nxt[dsi_pkg::ST_LOCK_BIT] = lock_r;
         end
         dsi_pkg::OFF_CRC_STATE: begin
            rdata_nxt[2:0] = crc_r;
         end
         default: begin
            rdata_nxt = 8'h00;
         end
      endcase
   end

   // Read data is registered on the read strobe.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= rdata_nxt;
      end
   end

   // Held reset towards the system domain; it never reaches this port.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         SYSTEM_RESET_HOLD <= 1'b0;
      end else begin
         SYSTEM_RESET_HOLD <= reset_hold_r;
      end
   end

   // Clock request towards the system, high while the stored bit is set.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         SYSTEM_CLOCK_REQUEST <= 1'b0;
      end else begin
         SYSTEM_CLOCK_REQUEST <= system_clock_request_r;
      end
   end

   // One-cycle commit pulse towards the flash controller.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         USER_ROW_COMMIT <= 1'b0;
      end else begin
         USER_ROW_COMMIT <= commit_r;
      end
   end

   // Debug clock choice towards the clock generator.
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         DEBUG_CLOCK_CHOICE <= dsi_pkg::CLK_SEL_RESET;
      end else begin
         DEBUG_CLOCK_CHOICE <= clk_sel_r;
      end
   end
endmodule : dsi_regs

// ---- rtl/dsi_sync.sv ----
// Three-stage synchroniser bank for status levels from the system domain.
module dsi_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Asynchronous levels in, filtered levels out.
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // Each bit has its own chain; it changes once stages two and three agree.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               s1_r[g] <= 1'b0;
               s2_r[g] <= 1'b0;
               s3_r[g] <= 1'b0;
               dout[g] <= 1'b0;
            end else begin
               s1_r[g] <= din[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               if (s2_r[g] == s3_r[g]) begin
                  dout[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate
endmodule : dsi_sync

// ---- testbench/dsi_debugger.sv ----
// Debugger model that issues accesses on the register port.
module dsi_debugger (
   // Clock and access port.
   input wire logic clk,
   output logic [3:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle port at time zero.
   initial {addr, wr, rd, wdata} = '0;
   // One write strobe; data is inverted once released.
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(negedge clk);
      wr <= 1'b0;
      wdata <= ~d;
   endtask : wr_reg
   // One read strobe; the answer is taken a cycle later.
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk);
      addr <= a;
      rd <= 1'b1;
      @(negedge clk);
      rd <= 1'b0;
      d = rdata;
   endtask : rd_reg
endmodule : dsi_debugger

// ---- testbench/dsi_regs_asserts.sv ----
// Checker of the debug system interface register block.
module dsi_regs_asserts (
   // Clock, reset and enable.
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic PORT_ENABLE,
   // Register port.
   input wire logic [3:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   // Key level from the decoder.
   input wire logic USER_ROW_WRITE_KEY_IN,
   // Controls towards the system.
   input wire logic SYSTEM_RESET_HOLD,
   input wire logic SYSTEM_CLOCK_REQUEST,
   input wire logic USER_ROW_COMMIT,
   input wire logic [1:0] DEBUG_CLOCK_CHOICE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);
   // Decoded writes of the port.
   wire logic rw = REG_WR && REG_ADDR == 4'h8;
   wire logic sg = REG_WDATA == dsi_pkg::RESET_SIGNATURE;
   wire logic cw = REG_WR && REG_ADDR == 4'ha && REG_WDATA[1];
   wire logic sw = REG_WR && PORT_ENABLE && REG_ADDR == 4'h9;
   wire logic [1:0] ws = REG_WDATA[1:0];
   a_hold_set: assert property (rw && sg |-> ##2 SYSTEM_RESET_HOLD)
      else $error("reset hold not raised");
   a_hold_drop: assert property (
      rw && !sg |-> ##2 !SYSTEM_RESET_HOLD)
      else $error("reset hold not released");
   a_commit_cause: assert property (USER_ROW_COMMIT |->
      $past(cw, 2) && $past(USER_ROW_WRITE_KEY_IN, 3))
      else $error("commit pulse without keyed commit write");
   a_system_clock_request_enable: assert property (
      $rose(PORT_ENABLE) |-> ##2 SYSTEM_CLOCK_REQUEST)
      else $error("clock request not raised on enable");
   a_sel_follow: assert property (
      sw && ws != 2'h0 |-> ##2 DEBUG_CLOCK_CHOICE == $past(ws, 2))
      else $error("clock choice not taken");
   a_sel_legal: assert property (DEBUG_CLOCK_CHOICE != 2'h0)
      else $error("reserved clock choice");
   a_unmapped_zero: assert property (
      REG_RD && (REG_ADDR < 4'h7 || REG_ADDR > 4'hc) |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without read");
   a_disable_wipe: assert property (
      !PORT_ENABLE [*3] |-> DEBUG_CLOCK_CHOICE == 2'h3 && !SYSTEM_CLOCK_REQUEST)
      else $error("disable did not wipe port state");
endmodule : dsi_regs_asserts

bind dsi_regs dsi_regs_asserts i_chk (
   .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PORT_ENABLE(PORT_ENABLE),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .USER_ROW_WRITE_KEY_IN(USER_ROW_WRITE_KEY_IN),
   .SYSTEM_RESET_HOLD(SYSTEM_RESET_HOLD), .USER_ROW_COMMIT(USER_ROW_COMMIT),
   .SYSTEM_CLOCK_REQUEST(SYSTEM_CLOCK_REQUEST),
   .DEBUG_CLOCK_CHOICE(DEBUG_CLOCK_CHOICE));

// ---- testbench/test_dsi_regs.sv ----
// Self-checking bench of the debug system interface registers.
module test_dsi_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, en, ku, kp, ke, dp, de, slp, fpr, urr, lck, wr, rd;
   logic hold, creq, com;
   logic [1:0] sel, e, w;
   logic [2:0] crc;
   logic [3:0] addr, s;
   logic [7:0] wdata, rdata, w8;
   int fails, checks, seed, cyc, ncom;
   logic [2:0] crc_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   // The held system reset is fed back as the system's reset state.
   dsi_regs i_dut (.CLK_SYS(clk), .SYS_RST(rst), .PORT_ENABLE(en),
      .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .USER_ROW_WRITE_KEY_IN(ku),
      .FLASH_PROGRAM_KEY_IN(kp), .ERASE_KEY_IN(ke), .PROG_DONE_IN(dp),
      .ERASE_DONE_IN(de), .SYSTEM_RESET_IN(hold), .SYSTEM_ASLEEP_IN(slp),
      .FLASH_PROG_READY_IN(fpr), .USER_ROW_PROG_READY_IN(urr),
      .DEVICE_LOCKED_IN(lck), .CRC_STATE_IN(crc),
      .SYSTEM_RESET_HOLD(hold), .SYSTEM_CLOCK_REQUEST(creq),
      .USER_ROW_COMMIT(com), .DEBUG_CLOCK_CHOICE(sel));
   dsi_debugger i_dbg (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
      .wdata(wdata), .rdata(rdata));
   // Clock of 5 ns period.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Cycle ceiling and count of commit pulses.
   always @(posedge clk) begin
      cyc++;
      if (com === 1'b1) ncom++;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
   end
   // Expected system state from sleep, ready, ready and lock levels.
   function automatic logic [7:0] st_exp(input logic [3:0] v);
      return {3'h0, v[3:1], 1'b0, v[0]};
   endfunction : st_exp
   // Compares and counts.
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      checks++;
      if (g !== x) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   // Reads a register and compares it.
   task automatic rdc(input logic [3:0] a, input logic [7:0] x);
      logic [7:0] v;
      i_dbg.rd_reg(a, v);
      chk(v, x);
   endtask : rdc
   // Prints the counts and the verdict.
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   // Main sequence: reset request, control and key, status and disable tests.
   initial begin
      seed = 32'h747c;
      {en, ku, kp, ke, dp, de, slp, fpr, urr, crc} = '0;
      lck = 1'b1;
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst <= 1'b0;
      en <= 1'b1;
      rdc(4'hb, dsi_pkg::SYS_STATE_RESET);
      rdc(4'ha, 8'h01);
      chk({7'h0, creq}, 8'h01);
      chk({6'h0, sel}, {6'h0, dsi_pkg::CLK_SEL_RESET});
      e = dsi_pkg::CLK_SEL_RESET;
      for (int v = 1; v < 5; v++) begin
         w = 2'(v * 3);
         if (w != 2'h0) e = w;
         i_dbg.wr_reg(4'h9, {6'h3f, w});
         rdc(4'h9, {6'h0, e});
         chk({6'h0, sel}, {6'h0, e});
      end
      i_dbg.wr_reg(4'h8, dsi_pkg::RESET_SIGNATURE);
      repeat (6) @(negedge clk);
      rdc(4'h8, 8'h01);
      rdc(4'h9, {6'h0, e});
      rdc(4'hb, 8'h21);
      chk({7'h0, hold}, 8'h01);
      w8 = 8'($random(seed));
      i_dbg.wr_reg(4'h8, w8 ^ {7'h0, w8 == 8'h59});
      repeat (8) @(negedge clk);
      chk({7'h0, hold}, 8'h00);
      rdc(4'h8, 8'h00);
      rdc(4'hb, 8'h21);
      rdc(4'hb, 8'h01);
      $display("Reset request test done");
      i_dbg.wr_reg(4'ha, 8'h02);
      rdc(4'h7, 8'h00);
      ku <= 1'b1;
      rdc(4'h7, 8'h20);
      i_dbg.wr_reg(4'ha, 8'h03);
      rdc(4'ha, 8'h01);
      chk({ncom[6:0], creq}, 8'h03);
      i_dbg.wr_reg(4'ha, 8'hfc);
      rdc(4'ha, 8'h00);
      chk({7'h0, creq}, 8'h00);
      for (int k = 0; k < 2; k++) begin
         {kp, ke} <= 2'(k + 1);
         {dp, de} <= 2'b00;
         rdc(4'h7, 8'h20 | (8'h08 << k));
         {kp, ke} <= 2'b00;
         {dp, de} <= 2'(k + 1);
         rdc(4'h7, 8'h20);
      end
      {dp, de} <= 2'b00;
      $display("Control and key test done");
      repeat (20) begin
         s = 4'($random(seed));
         {slp, fpr, urr, lck} <= s;
         crc <= crc_tab[2'($random(seed))];
         repeat (6) @(negedge clk);
         rdc(4'hb, st_exp(s));
         rdc(4'hc, {5'h0, crc});
      end
      i_dbg.wr_reg(4'hc, 8'hff);
      rdc(4'hc, {5'h0, crc});
      rdc(4'hf, 8'h00);
      kp <= 1'b1;
      i_dbg.wr_reg(4'h9, 8'h01);
      repeat (2) @(negedge clk);
      rdc(4'h7, 8'h30);
      kp <= 1'b0;
      en <= 1'b0;
      repeat (4) @(negedge clk);
      chk({7'h0, creq}, 8'h00);
      en <= 1'b1;
      rdc(4'h9, 8'h03);
      rdc(4'h7, 8'h20);
      rdc(4'ha, 8'h01);
      chk({7'h0, creq}, 8'h01);
      chk({6'h0, sel}, 8'h03);
      $display("Status and disable test done");
      end_of_test();
   end
endmodule : test_dsi_regs
